// ===== design/hm_pkg.sv
package hm_pkg;

   // Clock and timing
   localparam int CLK_PERIOD_NS = 5;
   localparam int CONV_PERIOD_NS = 700000;
   localparam int CONV_PERIOD_CYC = CONV_PERIOD_NS / CLK_PERIOD_NS;
   localparam int CONV_CNT_W = 18;
   localparam int IDLE_GAP_NS = 14000;
   localparam int IDLE_GAP_CYC = (IDLE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int GAP_CNT_W = 12;

   // Conversion code format
   localparam int ADC_W = 10;
   localparam int ADC_RAW_W = 11;
   localparam logic [ADC_W-1:0] ADC_CODE_MAX = 10'h3ff;
   localparam logic [ADC_W-1:0] ADC_CODE_NOMINAL = 10'h300;

   // Single-channel select codes
   localparam int NUM_CHAN = 10;
   localparam logic [3:0] CH_P2V5 = 4'h0;
   localparam logic [3:0] CH_CPU_CORE_SUPPLY = 4'h1;
   localparam logic [3:0] CH_OWN_SUPPLY = 4'h2;
   localparam logic [3:0] CH_P5V = 4'h3;
   localparam logic [3:0] CH_P12V = 4'h4;
   localparam logic [3:0] CH_REMOTE_1 = 4'h5;
   localparam logic [3:0] CH_LOCAL = 4'h6;
   localparam logic [3:0] CH_REMOTE_2 = 4'h7;
   localparam logic [3:0] CH_PROC_TERM_VOLTAGE = 4'h8;
   localparam logic [3:0] CH_CPU_CURRENT_MONITOR = 4'h9;

   // Select field inside the first fan-speed minimum high byte
   localparam int SEL_MSB = 7;
   localparam int SEL_LSB = 4;

   // Processor polling
   localparam int NUM_SLOTS = 4;
   localparam int TEMP_W = 8;
   localparam logic [7:0] PECI_ADDR_BASE = 8'h30;
   localparam logic [7:0] PECI_ADDR_LAST = 8'h33;

   typedef enum logic [1:0] {
      PS_IDLE,
      PS_ISSUE,
      PS_WAIT,
      PS_GAP
   } hm_poll_state_t;

   typedef struct packed {
      logic [7:0] fan_hi;
      logic [CONV_CNT_W-1:0] cnt;
      logic start;
      logic pending;
      logic [3:0] chan;
      logic [NUM_CHAN-1:0][ADC_W-1:0] res;
   } hm_adc_state_t;

   typedef struct packed {
      hm_poll_state_t st;
      logic [1:0] slot;
      logic dom;
      logic have;
      logic [TEMP_W-1:0] best;
      logic req;
      logic [7:0] addr;
      logic [GAP_CNT_W-1:0] gap;
      logic [NUM_SLOTS-1:0][TEMP_W-1:0] rd;
   } hm_poll_reg_t;

endpackage : hm_pkg

// ===== design/hm_adc_select.sv
`timescale 1ns/100ps
module hm_adc_select #(
   parameter int CONV_CYC = hm_pkg::CONV_PERIOD_CYC
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   // Configuration
   input wire logic single_mode_i,
   input wire logic fan1_min_hi_wr_i,
   input wire logic [7:0] fan1_min_hi_data_i,
   output logic [7:0] fan1_min_hi_o,
   // Converter
   output logic adc_start_o,
   output logic [3:0] adc_chan_o,
   input wire logic adc_done_i,
   input wire logic [hm_pkg::ADC_RAW_W-1:0] adc_code_i,
   // Results
   output logic [hm_pkg::NUM_CHAN-1:0][hm_pkg::ADC_W-1:0] chan_result_o
);

   localparam int CW = hm_pkg::CONV_CNT_W;
   localparam logic [CW-1:0] CNT_LAST = CW'(CONV_CYC - 1);

   hm_pkg::hm_adc_state_t st_ff;
   hm_pkg::hm_adc_state_t nxt_st;
   logic [3:0] sel;

   function automatic logic chan_valid(input logic [3:0] c);
      return c < 4'(hm_pkg::NUM_CHAN);
   endfunction : chan_valid

   function automatic logic [hm_pkg::ADC_W-1:0] saturate(input logic [hm_pkg::ADC_RAW_W-1:0] raw);
      if (raw > {1'b0, hm_pkg::ADC_CODE_MAX}) begin
         return hm_pkg::ADC_CODE_MAX;
      end
      return raw[hm_pkg::ADC_W-1:0];
   endfunction : saturate

   // Select field is simply the upper nibble of the stored fan byte
   assign sel = st_ff.fan_hi[hm_pkg::SEL_MSB:hm_pkg::SEL_LSB];

   always_comb begin
      nxt_st = st_ff;
      nxt_st.start = 1'b0;
      if (fan1_min_hi_wr_i) begin
         nxt_st.fan_hi = fan1_min_hi_data_i;
      end
      if (!single_mode_i) begin
         nxt_st.cnt = '0;
      end else if (st_ff.cnt == CNT_LAST) begin
         nxt_st.cnt = '0;
         // Undefined codes start nothing, so no result moves
         if (chan_valid(sel) && !st_ff.pending) begin
            nxt_st.start = 1'b1;
            nxt_st.chan = sel;
            nxt_st.pending = 1'b1;
         end
      end else begin
         nxt_st.cnt = st_ff.cnt + 1'b1;
      end
      // Channel latched at start, so a reselect mid-conversion cannot misroute
      if (st_ff.pending && adc_done_i) begin
         nxt_st.pending = 1'b0;
         nxt_st.res[st_ff.chan] = saturate(adc_code_i);
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign fan1_min_hi_o = st_ff.fan_hi;
   assign adc_start_o = st_ff.start;
   assign adc_chan_o = st_ff.chan;
   assign chan_result_o = st_ff.res;

   default clocking adc_cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!reset_n_i);

   a_start_valid_chan: assert property (adc_start_o |-> chan_valid(adc_chan_o))
      else $error("conversion started on undefined channel");
   a_start_single_only: assert property (adc_start_o |-> $past(single_mode_i) && !$past(st_ff.pending))
      else $error("conversion started outside single-channel mode");
   a_start_spacing: assert property (adc_start_o |=> !adc_start_o [*8])
      else $error("conversions started too close together");
   a_saturate_top: assert property (st_ff.pending && adc_done_i && adc_code_i > {1'b0, hm_pkg::ADC_CODE_MAX}
         |=> chan_result_o[$past(st_ff.chan)] == hm_pkg::ADC_CODE_MAX)
      else $error("overrange code not clipped to top step");
   a_select_shared: assert property (fan1_min_hi_wr_i
         |=> fan1_min_hi_o == $past(fan1_min_hi_data_i)
             && sel == $past(fan1_min_hi_data_i[hm_pkg::SEL_MSB:hm_pkg::SEL_LSB]))
      else $error("select field does not track fan byte");

   c_conv_start: cover property (adc_start_o ##[1:20] adc_done_i);
   c_saturate: cover property (st_ff.pending && adc_done_i && adc_code_i > {1'b0, hm_pkg::ADC_CODE_MAX});

endmodule : hm_adc_select

// ===== design/hm_chan_monitor.sv
`timescale 1ns/100ps
// Notes on behaviour
// - Four-bit code picks one of ten sources
// - Select nibble lives in fan minimum byte
// - Results unsigned ten bits, clipped at 1023
// - Local, two remote, four digital temperatures
// - Block polls processors, never waits for reports
// - Readings kept raw, relative to throttle point
// - Polls start only while enable set
// - Poll one to four processors per count
// - Read all domains, keep hottest only
// - One domain-count bit per processor slot
// - Single mode converts selection every 0.7 ms
// - Slots 0..3 use addresses 0x30..0x33
module hm_chan_monitor #(
   parameter int CONV_PERIOD_CYC = hm_pkg::CONV_PERIOD_CYC
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   // Conversion configuration
   input wire logic single_mode_i,
   input wire logic fan1_min_hi_wr_i,
   input wire logic [7:0] fan1_min_hi_data_i,
   output logic [7:0] fan1_min_hi_o,
   // Converter handshake
   output logic adc_start_o,
   output logic [3:0] adc_chan_o,
   input wire logic adc_done_i,
   input wire logic [hm_pkg::ADC_RAW_W-1:0] adc_code_i,
   output logic [hm_pkg::NUM_CHAN-1:0][hm_pkg::ADC_W-1:0] chan_result_o,
   // Processor polling configuration
   input wire logic peci_enable_i,
   input wire logic [1:0] cpu_count_i,
   input wire logic [hm_pkg::NUM_SLOTS-1:0] dom_two_i,
   // Transaction engine on the wire
   output logic peci_req_o,
   output logic [7:0] peci_addr_o,
   output logic peci_domain_o,
   input wire logic peci_done_i,
   input wire logic peci_err_i,
   input wire logic [hm_pkg::TEMP_W-1:0] peci_temp_i,
   // Processor readings
   output logic [hm_pkg::TEMP_W-1:0] cpu_reading_slot_0_o,
   output logic [hm_pkg::TEMP_W-1:0] cpu_reading_slot_1_o,
   output logic [hm_pkg::TEMP_W-1:0] cpu_reading_slot_2_o,
   output logic [hm_pkg::TEMP_W-1:0] cpu_reading_slot_3_o
);

   localparam int GW = hm_pkg::GAP_CNT_W;
   localparam logic [GW-1:0] GAP_LAST = GW'(hm_pkg::IDLE_GAP_CYC - 1);

   hm_pkg::hm_poll_reg_t st_ff;
   hm_pkg::hm_poll_reg_t nxt_st;
   logic temp_ok;
   logic last_dom;
   logic [hm_pkg::TEMP_W-1:0] hot;

   function automatic logic [7:0] slot_addr(input logic [1:0] s);
      return hm_pkg::PECI_ADDR_BASE + {6'h00, s};
   endfunction : slot_addr

   hm_adc_select #(
      .CONV_CYC(CONV_PERIOD_CYC)
   ) u_adc_select (
      .ref_clk_i(ref_clk_i),
      .reset_n_i(reset_n_i),
      .single_mode_i(single_mode_i),
      .fan1_min_hi_wr_i(fan1_min_hi_wr_i),
      .fan1_min_hi_data_i(fan1_min_hi_data_i),
      .fan1_min_hi_o(fan1_min_hi_o),
      .adc_start_o(adc_start_o),
      .adc_chan_o(adc_chan_o),
      .adc_done_i(adc_done_i),
      .adc_code_i(adc_code_i),
      .chan_result_o(chan_result_o)
   );

   assign temp_ok = peci_done_i && !peci_err_i;
   assign last_dom = !dom_two_i[st_ff.slot] || st_ff.dom;
   // Signed compare: closer to zero means closer to throttling
   assign hot = (st_ff.have && ($signed(st_ff.best) > $signed(peci_temp_i)))
      ? st_ff.best
      : peci_temp_i;

   always_comb begin
      nxt_st = st_ff;
      unique case (st_ff.st)
         hm_pkg::PS_IDLE: begin
            if (peci_enable_i) begin
               nxt_st.slot = '0;
               nxt_st.dom = 1'b0;
               nxt_st.have = 1'b0;
               nxt_st.st = hm_pkg::PS_ISSUE;
            end
         end
         hm_pkg::PS_ISSUE: begin
            if (!peci_enable_i) begin
               nxt_st.st = hm_pkg::PS_IDLE;
            end else begin
               // Count may have shrunk while waiting out the gap
               if (st_ff.slot > cpu_count_i) begin
                  nxt_st.slot = '0;
                  nxt_st.addr = slot_addr(2'b00);
               end else begin
                  nxt_st.addr = slot_addr(st_ff.slot);
               end
               nxt_st.req = 1'b1;
               nxt_st.st = hm_pkg::PS_WAIT;
            end
         end
         hm_pkg::PS_WAIT: begin
            if (peci_done_i) begin
               nxt_st.req = 1'b0;
               if (temp_ok) begin
                  nxt_st.best = hot;
                  nxt_st.have = 1'b1;
               end
               if (!last_dom) begin
                  nxt_st.dom = 1'b1;
                  nxt_st.st = hm_pkg::PS_ISSUE;
               end else begin
                  // A failed read keeps the old reading unless an earlier domain read succeeded
                  if (temp_ok || st_ff.have) begin
                     nxt_st.rd[st_ff.slot] = temp_ok ? hot : st_ff.best;
                  end
                  nxt_st.dom = 1'b0;
                  nxt_st.have = 1'b0;
                  nxt_st.slot = (st_ff.slot >= cpu_count_i) ? 2'b00 : st_ff.slot + 1'b1;
                  nxt_st.gap = GAP_LAST;
                  nxt_st.st = hm_pkg::PS_GAP;
               end
            end
         end
         hm_pkg::PS_GAP: begin
            if (st_ff.gap == '0) begin
               nxt_st.st = peci_enable_i ? hm_pkg::PS_ISSUE : hm_pkg::PS_IDLE;
            end else begin
               nxt_st.gap = st_ff.gap - 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign peci_req_o = st_ff.req;
   assign peci_addr_o = st_ff.addr;
   assign peci_domain_o = st_ff.dom;
   assign cpu_reading_slot_0_o = st_ff.rd[0];
   assign cpu_reading_slot_1_o = st_ff.rd[1];
   assign cpu_reading_slot_2_o = st_ff.rd[2];
   assign cpu_reading_slot_3_o = st_ff.rd[3];

   default clocking poll_cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!reset_n_i);

   a_poll_needs_enable: assert property ($rose(peci_req_o) |-> $past(peci_enable_i))
      else $error("poll issued while polling disabled");
   a_addr_window: assert property (peci_req_o
         |-> peci_addr_o >= hm_pkg::PECI_ADDR_BASE && peci_addr_o <= hm_pkg::PECI_ADDR_LAST
             && peci_addr_o == hm_pkg::PECI_ADDR_BASE + 8'(st_ff.slot))
      else $error("poll address does not match slot");
   a_slot_in_count: assert property ($rose(peci_req_o) |-> st_ff.slot <= $past(cpu_count_i))
      else $error("slot beyond configured processor count");
   a_req_held: assert property (peci_req_o && !peci_done_i |=> peci_req_o)
      else $error("poll request dropped before answer");
   a_hottest_kept: assert property (st_ff.st == hm_pkg::PS_WAIT && temp_ok && last_dom
         |=> $signed(st_ff.rd[$past(st_ff.slot)]) >= $signed($past(peci_temp_i)))
      else $error("stored reading cooler than a domain read");
   a_reading_raw: assert property (st_ff.st == hm_pkg::PS_WAIT && temp_ok && !dom_two_i[st_ff.slot]
         |=> st_ff.rd[$past(st_ff.slot)] == $past(peci_temp_i))
      else $error("single-domain reading altered");
   a_error_no_write: assert property (st_ff.st == hm_pkg::PS_WAIT && peci_done_i && peci_err_i
         && last_dom && !st_ff.have |=> $stable(st_ff.rd))
      else $error("failed read overwrote a reading");

   // Polling order and hand-over checks
   a_req_drops: assert property (peci_req_o && peci_done_i |=> !peci_req_o)
      else $error("poll request held past its answer");
   a_target_stable: assert property (peci_req_o && !peci_done_i
         |=> $stable(peci_addr_o) && $stable(peci_domain_o))
      else $error("poll target changed while waiting");
   a_off_quiet: assert property (!peci_enable_i && !peci_req_o |=> !peci_req_o)
      else $error("poll started while polling disabled");
   a_disable_idle: assert property (st_ff.st == hm_pkg::PS_ISSUE && !peci_enable_i
         |=> st_ff.st == hm_pkg::PS_IDLE && !peci_req_o)
      else $error("disabled poller did not return to idle");
   // Domain 1 follows only if polling is still on
   a_second_domain: assert property (st_ff.st == hm_pkg::PS_WAIT && peci_done_i && !last_dom
         |-> ##2 ((peci_req_o && peci_domain_o) || !$past(peci_enable_i)))
      else $error("second domain of a processor not read");
   a_single_domain: assert property (st_ff.st == hm_pkg::PS_WAIT && peci_done_i && !dom_two_i[st_ff.slot]
         |=> st_ff.st == hm_pkg::PS_GAP)
      else $error("extra domain read on a single-domain processor");
   a_slot_fresh: assert property (st_ff.st == hm_pkg::PS_GAP |-> !st_ff.dom && !st_ff.have)
      else $error("domain state carried into the next processor");
   a_slot_wrap: assert property (st_ff.st == hm_pkg::PS_WAIT && peci_done_i && last_dom
         && st_ff.slot == cpu_count_i |=> st_ff.slot == '0)
      else $error("poll did not wrap after the last processor");
   // Count may shrink while a later slot waits out its gap
   a_slot_shrink: assert property (st_ff.st == hm_pkg::PS_ISSUE && peci_enable_i
         && st_ff.slot > cpu_count_i |=> peci_addr_o == hm_pkg::PECI_ADDR_BASE)
      else $error("shrunk count did not restart at the first processor");
   // Gap keeps the wire idle between processors
   a_gap_holds: assert property (st_ff.st == hm_pkg::PS_GAP && st_ff.gap != '0
         |=> st_ff.st == hm_pkg::PS_GAP)
      else $error("next poll started before the idle gap ran out");

   c_two_domains: cover property (st_ff.st == hm_pkg::PS_WAIT && temp_ok && st_ff.dom);
   c_four_slots: cover property (st_ff.st == hm_pkg::PS_WAIT && temp_ok && last_dom && st_ff.slot == 2'b11);
   c_error_read: cover property (st_ff.st == hm_pkg::PS_WAIT && peci_done_i && peci_err_i);

endmodule : hm_chan_monitor

// ===== dv/hm_cpu_model.sv
`timescale 1ns/100ps
module hm_cpu_model (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   // Scenario setup
   input wire logic [3:0][1:0][7:0] temps_i,
   input wire logic [3:0][1:0] fail_i,
   input wire logic [7:0] delay_i,
   // Request side
   input wire logic req_i,
   input wire logic [7:0] addr_i,
   input wire logic domain_i,
   // Answer side
   output logic done_o,
   output logic err_o,
   output logic [7:0] temp_o
);
   logic [7:0] cnt;
   logic answered;
   always @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         done_o <= 1'b0;
         err_o <= 1'b0;
         temp_o <= 8'h00;
         cnt <= 8'h00;
         answered <= 1'b0;
      end else begin
         done_o <= 1'b0;
         // Answer lines toggle outside the done cycle so stale data never matches
         err_o <= ~err_o;
         temp_o <= ~temp_o;
         if (!req_i) begin
            answered <= 1'b0;
            cnt <= 8'h00;
         end else if (!answered && !done_o) begin
            if (cnt == delay_i) begin
               done_o <= 1'b1;
               answered <= 1'b1;
               err_o <= fail_i[addr_i[1:0]][domain_i];
               temp_o <= temps_i[addr_i[1:0]][domain_i];
            end else begin
               cnt <= cnt + 8'h01;
            end
         end
      end
   end
endmodule : hm_cpu_model

// ===== dv/tb.sv
`timescale 1ns/100ps
module tb;
   localparam int CONV = 20;
   logic ref_clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic single_mode = 1'b0;
   logic fan_wr = 1'b0;
   logic [7:0] fan_data = 8'h00;
   logic [7:0] fan_byte;
   logic adc_start;
   logic [3:0] adc_chan;
   logic adc_done = 1'b0;
   logic [hm_pkg::ADC_RAW_W-1:0] adc_code = 11'h000;
   logic [hm_pkg::NUM_CHAN-1:0][hm_pkg::ADC_W-1:0] chan_res;
   logic [hm_pkg::NUM_CHAN-1:0][hm_pkg::ADC_W-1:0] saved;
   logic peci_en = 1'b0;
   logic [1:0] cpu_count = 2'b11;
   logic [3:0] dom_two = 4'b0101;
   logic req;
   logic dom;
   logic done;
   logic err;
   logic [7:0] addr;
   logic [7:0] temp;
   logic [3:0][7:0] rd;
   logic [3:0][1:0][7:0] temps;
   logic [3:0][1:0] fails;
   logic [7:0] delay = 8'h03;
   logic req_ff = 1'b0;
   logic [8:0] seen_q[$];
   int num_errors = 0;
   int checks_done = 0;
   int cyc = 0;
   int starts = 0;
   int last = 0;
   int n;

   hm_chan_monitor #(.CONV_PERIOD_CYC(CONV)) dut_u (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
      .single_mode_i(single_mode), .fan1_min_hi_wr_i(fan_wr), .fan1_min_hi_data_i(fan_data),
      .fan1_min_hi_o(fan_byte), .adc_start_o(adc_start), .adc_chan_o(adc_chan), .adc_done_i(adc_done),
      .adc_code_i(adc_code), .chan_result_o(chan_res), .peci_enable_i(peci_en), .cpu_count_i(cpu_count),
      .dom_two_i(dom_two), .peci_req_o(req), .peci_addr_o(addr), .peci_domain_o(dom), .peci_done_i(done),
      .peci_err_i(err), .peci_temp_i(temp), .cpu_reading_slot_0_o(rd[0]), .cpu_reading_slot_1_o(rd[1]),
      .cpu_reading_slot_2_o(rd[2]), .cpu_reading_slot_3_o(rd[3]));

   hm_cpu_model cpu_u (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .temps_i(temps), .fail_i(fails),
      .delay_i(delay), .req_i(req), .addr_i(addr), .domain_i(dom), .done_o(done), .err_o(err), .temp_o(temp));

   always #2.5 ref_clk_i = ~ref_clk_i;

   always @(posedge ref_clk_i) begin
      cyc <= cyc + 1;
      req_ff <= req;
      if (adc_start === 1'b1) starts <= starts + 1;
      if (req === 1'b1 && req_ff === 1'b0) seen_q.push_back({addr, dom});
      // Whole plan needs about 23k cycles
      if (cyc == 40000) begin
         num_errors++;
         tally_and_finish();
      end
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic fan_write(input logic [7:0] d);
      @(negedge ref_clk_i);
      fan_wr = 1'b1;
      fan_data = d;
      @(negedge ref_clk_i);
      fan_wr = 1'b0;
      check("fan byte", {24'h0, fan_byte}, {24'h0, d});
   endtask : fan_write

   task automatic convert(input logic [3:0] c, input logic [10:0] raw, input logic [9:0] exp);
      fan_write({c, 4'h5});
      single_mode = 1'b1;
      while (adc_start !== 1'b1) begin
         @(posedge ref_clk_i);
         #1;
      end
      check("chan", {28'h0, adc_chan}, {28'h0, c});
      if (c != 4'h0) check("period", cyc - last, CONV);
      last = cyc;
      @(negedge ref_clk_i);
      adc_done = 1'b1;
      adc_code = raw;
      @(negedge ref_clk_i);
      adc_done = 1'b0;
      @(negedge ref_clk_i);
      check("result", {22'h0, chan_res[c]}, {22'h0, exp});
   endtask : convert

   task automatic tally_and_finish();
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : tally_and_finish

   initial begin
      temps = '0;
      fails = '0;
      temps[0] = {8'hFB, 8'hF6};
      temps[1] = {8'h7F, 8'hEC};
      temps[2] = {8'hE2, 8'h05};
      temps[3] = {8'h7F, 8'hFF};
      // Failed answer must not win even though it is hotter
      fails[0][1] = 1'b1;
      repeat (2) @(negedge ref_clk_i);
      reset_n_i = 1'b1;
      @(negedge ref_clk_i);
      check("reset fan", {24'h0, fan_byte}, 32'h0);
      check("reset rd", rd, 32'h0);
      check("reset res", {31'h0, chan_res === '0}, 1);
      // Code 3 above range, code 4 just above top step, code 8 nominal
      for (int c = 0; c < 10; c++) begin
         convert(4'(c), (c == 3) ? 11'h7ff : (c == 4) ? 11'h400 : 11'h2f8 + 11'(c),
                 (c == 3 || c == 4) ? 10'h3ff : 10'h2f8 + 10'(c));
      end
      saved = chan_res;
      fan_write(8'hC5);
      n = starts;
      @(negedge ref_clk_i);
      adc_done = 1'b1;
      adc_code = 11'h0aa;
      @(negedge ref_clk_i);
      adc_done = 1'b0;
      repeat (3 * CONV) @(negedge ref_clk_i);
      check("no start", starts, n);
      check("held res", {31'h0, chan_res === saved}, 1);
      single_mode = 1'b0;
      peci_en = 1'b1;
      while (seen_q.size() < 7) @(negedge ref_clk_i);
      foreach (seen_q[i]) if (i < 7) check("poll", {23'h0, seen_q[i]},
         {23'h0, i == 6 ? 9'h060 : 9'({8'h30 + 8'(i - (i > 0) - (i > 3)), i == 1 || i == 4})});
      check("slot0", {24'h0, rd[0]}, 32'hF6);
      check("slot1", {24'h0, rd[1]}, 32'hEC);
      check("slot2", {24'h0, rd[2]}, 32'h05);
      check("slot3", {24'h0, rd[3]}, 32'hFF);
      peci_en = 1'b0;
      repeat (60) @(negedge ref_clk_i);
      n = seen_q.size();
      repeat (3100) @(negedge ref_clk_i);
      check("disabled", seen_q.size(), n);
      delay = 8'h1f;
      // Single-domain read fails: old reading must stay
      fails[1][0] = 1'b1;
      seen_q.delete();
      peci_en = 1'b1;
      while (seen_q.size() < 3) @(negedge ref_clk_i);
      // Shrink the count while slot 2 waits out its gap
      repeat (100) @(negedge ref_clk_i);
      cpu_count = 2'b00;
      while (seen_q.size() < 6) @(negedge ref_clk_i);
      check("shrink from", {23'h0, seen_q[2]}, {23'h0, 9'h062});
      check("one cpu", {5'h0, seen_q[3], seen_q[4], seen_q[5]}, {5'h0, 9'h060, 9'h061, 9'h060});
      check("slot1 kept", {24'h0, rd[1]}, 32'hEC);
      tally_and_finish();
   end
endmodule : tb
